// *** inc/fhp_defs.svh ***
/*
 * Offsets, field positions, widths and reset values of the host port front end.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef FHP_DEFS_SVH
`define FHP_DEFS_SVH

// Input register address in hub-style cycles and in LPC memory cycles.
`define FHP_REG_HUB_ADDR   32'hFFBC_0100
`define FHP_REG_LPC_ADDR   32'hFF7C_0100
// Address bits A22-A19 carry the device select in LPC memory cycles.
`define FHP_SEL_MASK       32'h0078_0000
`define FHP_SEL_LSB        19
`define FHP_SEL_MSB        22
// Field widths.
`define FHP_GPI_W          5
`define FHP_STRAP_W        4
`define FHP_ROW_W          11
`define FHP_COL_W          8
`define FHP_ARR_W          19
`define FHP_DATA_W         8
// Reserved bits 7:5 of the input register read as zero.
`define FHP_REG_RESV       3'h0
// Reset values.
`define FHP_ADDR_RST       19'h0_0000
`define FHP_DATA_RST       8'h00

`endif

// *** inc/fhp_pkg.sv ***
/*
 * Types shared by the host port front end: request and answer carriers,
 * the bundle of synchronised pins and the host cycle states.
 * Assumes fhp_defs.svh is on the include path.
 */
`include "fhp_defs.svh"

package fhp_pkg;

    typedef struct packed {
        logic                      valid;
        logic                      hub;
        logic [`FHP_STRAP_W-1:0]   sel_field;
        logic [31:0]               addr;
        logic                      write;
    } fhp_req_type;

    typedef struct packed {
        logic                      valid;
        logic                      claim;
        logic                      reg_hit;
        logic [`FHP_DATA_W-1:0]    rdata;
    } fhp_rsp_type;

    typedef struct packed {
        logic [`FHP_GPI_W-1:0]     gpi;
        logic [`FHP_STRAP_W-1:0]   strap;
        logic                      ic;
        logic                      frame_b;
        logic                      rc;
        logic [`FHP_ROW_W-1:0]     a;
        logic                      oe_b;
        logic                      we_b;
        logic                      prst_b;
        logic [`FHP_DATA_W-1:0]    din;
    } fhp_pins_type;

    typedef enum logic [1:0] {
        FHP_IDLE,
        FHP_CLAIMED,
        FHP_IGNORE
    } fhp_host_state_type;

endpackage

// *** rtl/fhp_select.sv ***
/*
 * Device select comparator: strap against the cycle select field in hub
 * cycles, inverted strap against A22-A19 in LPC memory cycles.
 * Assumes synchronised strap levels from the caller.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fhp_defs.svh"

module fhp_select (
    // Strap and cycle fields.
    input  wire logic [`FHP_STRAP_W-1:0] strap,
    input  wire logic                    hub,
    input  wire logic [`FHP_STRAP_W-1:0] sel_field,
    input  wire logic [`FHP_STRAP_W-1:0] sel_addr,
    // Result.
    output logic                         match
);
    // Hub cycles compare directly, LPC cycles against the inverse.
    assign match = hub ? (sel_field == strap) : (sel_addr == ~strap);

endmodule
`default_nettype wire

// *** rtl/fhp_mux_port.sv ***
/*
 * Multiplexed-address programming port: row/column latching, read drive
 * and write capture toward the memory array.
 * Assumes pins already synchronised to clk and a same-clock array.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fhp_defs.svh"

module fhp_mux_port
    import fhp_pkg::*;
(
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Mode, pins and array read data.
    input  wire logic                   en,
    input  wire fhp_pkg::fhp_pins_type  pins,
    input  wire logic [`FHP_DATA_W-1:0] array_rdata,
    // Array side.
    output logic [`FHP_ARR_W-1:0]       addr_ff,
    output logic                        wr_ff,
    output logic [`FHP_DATA_W-1:0]      wdata_ff,
    // Data pins.
    output logic [`FHP_DATA_W-1:0]      dout_ff,
    output logic                        doe_ff
);
    logic                     rc_ff;
    logic                     we_ff;
    logic [`FHP_ROW_W-1:0]    row_ff;
    logic [`FHP_COL_W-1:0]    col_ff;
    logic                     nxt_rc;
    logic                     nxt_we;
    logic [`FHP_ROW_W-1:0]    nxt_row;
    logic [`FHP_COL_W-1:0]    nxt_col;
    logic                     nxt_wr;
    logic [`FHP_DATA_W-1:0]   nxt_wdata;
    logic                     nxt_doe;
    logic                     live;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        live      = en && pins.prst_b;
        nxt_rc    = pins.rc;
        nxt_we    = pins.we_b;
        nxt_row   = row_ff;
        nxt_col   = col_ff;
        nxt_wr    = 1'b0;
        nxt_wdata = wdata_ff;
        if (!live) begin
            nxt_row = '0;
            nxt_col = '0;
        end else begin
            if (rc_ff && !pins.rc) begin
                nxt_row = pins.a;
            end
            if (!rc_ff && pins.rc) begin
                nxt_col = pins.a[`FHP_COL_W-1:0];
            end
            if (!we_ff && pins.we_b && pins.oe_b) begin
                nxt_wr    = 1'b1;
                nxt_wdata = pins.din;
            end
        end
        nxt_doe = live && !pins.oe_b;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_ff    <= 1'b1;
            we_ff    <= 1'b1;
            row_ff   <= '0;
            col_ff   <= '0;
            wr_ff    <= 1'b0;
            wdata_ff <= `FHP_DATA_RST;
            dout_ff  <= `FHP_DATA_RST;
            doe_ff   <= 1'b0;
            addr_ff  <= `FHP_ADDR_RST;
        end else begin
            rc_ff    <= nxt_rc;
            we_ff    <= nxt_we;
            row_ff   <= nxt_row;
            col_ff   <= nxt_col;
            wr_ff    <= nxt_wr;
            wdata_ff <= nxt_wdata;
            dout_ff  <= array_rdata;
            doe_ff   <= nxt_doe;
            addr_ff  <= {nxt_col, nxt_row};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_row_latch: assert property (@(posedge clk) disable iff (!rst_n)
        (en && pins.prst_b && rc_ff && !pins.rc)
        |=> addr_ff[`FHP_ROW_W-1:0] == $past(pins.a))
        else $error("Row address not latched on strobe fall.");

    a_col_latch: assert property (@(posedge clk) disable iff (!rst_n)
        (en && pins.prst_b && !rc_ff && pins.rc)
        |=> addr_ff[`FHP_ARR_W-1:`FHP_ROW_W] == $past(pins.a[`FHP_COL_W-1:0]))
        else $error("Column address not latched on strobe rise.");

    a_read_drive: assert property (@(posedge clk) disable iff (!rst_n)
        (en && pins.prst_b) |=> (doe_ff == !$past(pins.oe_b)))
        else $error("Data drive does not follow read-drive.");

    a_write_capture: assert property (@(posedge clk) disable iff (!rst_n)
        (en && pins.prst_b && pins.oe_b && !we_ff && pins.we_b)
        |=> wr_ff && (wdata_ff == $past(pins.din)) ##1 !wr_ff)
        else $error("Write not captured once on strobe rise.");

endmodule
`default_nettype wire

// *** rtl/fhp_top.sv ***
/*
 * Host port front end of a boot flash: general input register, strap-based
 * device select with standby, and the multiplexed-address programming port.
 * Assumes a same-clock framing engine that decodes host cycles into
 * HOST_REQ, and a same-clock array that reports ARRAY_BUSY.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fhp_defs.svh"

module fhp_top
    import fhp_pkg::*;
(
    // Clock and reset.
    input  wire logic                    CLOCK,
    input  wire logic                    RST_B,
    // Host-side pins.
    input  wire logic [`FHP_GPI_W-1:0]   GENERAL_INPUTS,
    input  wire logic [`FHP_STRAP_W-1:0] STRAP_SELECT,
    input  wire logic                    INTERFACE_SELECT_PIN,
    input  wire logic                    FRAME_STROBE_B,
    // Decoded host cycles.
    input  wire fhp_pkg::fhp_req_type    HOST_REQ,
    output fhp_pkg::fhp_rsp_type         HOST_RSP,
    output logic                         NIBBLE_BUS_EN,
    output logic                         STANDBY,
    // Programming port pins.
    input  wire logic                    RC_STROBE,
    input  wire logic [`FHP_ROW_W-1:0]   ROW_COL_ADDR,
    input  wire logic                    READ_DRIVE_B,
    input  wire logic                    WRITE_STROBE_B,
    input  wire logic                    PROG_RESET_B,
    input  wire logic [`FHP_DATA_W-1:0]  PROG_DATA_I,
    output logic [`FHP_DATA_W-1:0]       PROG_DATA_O,
    output logic                         PROG_DATA_OE,
    // Memory array.
    input  wire logic                    ARRAY_BUSY,
    input  wire logic [`FHP_DATA_W-1:0]  ARRAY_RDATA,
    output logic [`FHP_ARR_W-1:0]        ARRAY_ADDR,
    output logic                         ARRAY_WRITE,
    output logic [`FHP_DATA_W-1:0]       ARRAY_WDATA,
    // Open-drain ready/busy.
    output logic                         READY_BUSY_O,
    output logic                         READY_BUSY_OE
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops.

    logic rst_meta_ff;
    logic rst_n;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. No reset, so the input register has no stored value.

    fhp_pins_type pins_raw;
    fhp_pins_type pins_meta_ff;
    fhp_pins_type pins_ff;

    always_comb begin
        pins_raw.gpi     = GENERAL_INPUTS;
        pins_raw.strap   = STRAP_SELECT;
        pins_raw.ic      = INTERFACE_SELECT_PIN;
        pins_raw.frame_b = FRAME_STROBE_B;
        pins_raw.rc      = RC_STROBE;
        pins_raw.a       = ROW_COL_ADDR;
        pins_raw.oe_b    = READ_DRIVE_B;
        pins_raw.we_b    = WRITE_STROBE_B;
        pins_raw.prst_b  = PROG_RESET_B;
        pins_raw.din     = PROG_DATA_I;
    end

    always_ff @(posedge CLOCK) begin
        pins_meta_ff <= pins_raw;
        pins_ff      <= pins_meta_ff;
    end

    logic prog_mode;
    logic frame_hi;

    assign prog_mode = pins_ff.ic;
    assign frame_hi  = pins_ff.frame_b;

    ////////////////////////////////////////////////////////////////////////////////
    // Device select and register decode.
    // Host requests come from same-clock decode logic and need no synchroniser.

    logic sel_match;

    fhp_select u_select (
        .strap     (pins_ff.strap),
        .hub       (HOST_REQ.hub),
        .sel_field (HOST_REQ.sel_field),
        .sel_addr  (HOST_REQ.addr[`FHP_SEL_MSB:`FHP_SEL_LSB]),
        .match     (sel_match)
    );

    // Register address for the cycle type, select bits excluded.
    function automatic logic reg_addr_hit(input logic hub, input logic [31:0] addr);
        logic [31:0] base;
        base = hub ? `FHP_REG_HUB_ADDR : `FHP_REG_LPC_ADDR;
        return ((addr ^ base) & ~`FHP_SEL_MASK) == 32'h0000_0000;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Host cycle tracking, answer and standby.

    fhp_host_state_type state_ff;
    fhp_host_state_type nxt_state;
    fhp_rsp_type        nxt_rsp;
    logic               nxt_nibble_en;
    logic               nxt_standby;
    logic               nxt_rb_oe;

    // A new request overrides whatever cycle is being tracked, so back-to-back
    // host cycles need no idle gap between them.
    always_comb begin
        nxt_state     = state_ff;
        nxt_rsp       = '0;
        nxt_nibble_en = NIBBLE_BUS_EN;
        unique case (state_ff)
            FHP_IDLE: begin
            end
            FHP_CLAIMED, FHP_IGNORE: begin
                if (frame_hi) begin
                    nxt_state     = FHP_IDLE;
                    nxt_nibble_en = 1'b0;
                end
            end
            default: begin
                nxt_state = FHP_IDLE;
            end
        endcase
        // Programming mode hides host requests: no answer and no new claim.
        if (HOST_REQ.valid && !prog_mode) begin
            nxt_rsp.valid = 1'b1;
            if (sel_match) begin
                nxt_rsp.claim   = 1'b1;
                nxt_rsp.reg_hit = reg_addr_hit(HOST_REQ.hub, HOST_REQ.addr)
                                  && !HOST_REQ.write;
                if (nxt_rsp.reg_hit) begin
                    nxt_rsp.rdata = {`FHP_REG_RESV, pins_ff.gpi};
                end
                nxt_state     = FHP_CLAIMED;
                nxt_nibble_en = 1'b1;
            end else begin
                nxt_state     = FHP_IGNORE;
                nxt_nibble_en = 1'b0;
            end
        end
        // Standby waits for a high frame strobe and an idle array, and is never
        // entered while a claimed cycle may still drive the nibble bus.
        nxt_standby = frame_hi && !ARRAY_BUSY && (nxt_state != FHP_CLAIMED);
        nxt_rb_oe   = ARRAY_BUSY;
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            state_ff      <= FHP_IDLE;
            HOST_RSP      <= '0;
            NIBBLE_BUS_EN <= 1'b0;
            STANDBY       <= 1'b0;
            READY_BUSY_OE <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            HOST_RSP      <= nxt_rsp;
            NIBBLE_BUS_EN <= nxt_nibble_en;
            STANDBY       <= nxt_standby;
            READY_BUSY_OE <= nxt_rb_oe;
        end
    end

    // Open-drain: only ever pulls low.
    assign READY_BUSY_O = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Programming port.

    fhp_mux_port u_mux_port (
        .clk         (CLOCK),
        .rst_n       (rst_n),
        .en          (prog_mode),
        .pins        (pins_ff),
        .array_rdata (ARRAY_RDATA),
        .addr_ff     (ARRAY_ADDR),
        .wr_ff       (ARRAY_WRITE),
        .wdata_ff    (ARRAY_WDATA),
        .dout_ff     (PROG_DATA_O),
        .doe_ff      (PROG_DATA_OE)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_gpi_read_value: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (HOST_REQ.valid && !prog_mode && sel_match && !HOST_REQ.write
         && reg_addr_hit(HOST_REQ.hub, HOST_REQ.addr))
        |=> HOST_RSP.reg_hit && HOST_RSP.rdata == {3'h0, $past(pins_ff.gpi)})
        else $error("Input register did not return pin levels.");

    a_reg_host_only: assert property (@(posedge CLOCK) disable iff (!rst_n)
        HOST_RSP.valid |-> !$past(prog_mode) && (HOST_RSP.reg_hit || HOST_RSP.rdata == 8'h00))
        else $error("Host answer given in programming mode.");

    a_prog_no_answer: assert property (@(posedge CLOCK) disable iff (!rst_n)
        prog_mode |=> !HOST_RSP.valid)
        else $error("Host cycle answered in programming mode.");

    a_hub_match_claim: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (HOST_REQ.valid && !prog_mode && HOST_REQ.hub
         && HOST_REQ.sel_field == pins_ff.strap)
        |=> HOST_RSP.claim && NIBBLE_BUS_EN)
        else $error("Hub cycle with matching select not claimed.");

    a_lpc_select: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (HOST_REQ.valid && !prog_mode && !HOST_REQ.hub)
        |=> HOST_RSP.claim == ($past(HOST_REQ.addr[22:19]) == ~$past(pins_ff.strap)))
        else $error("LPC select does not follow inverted strap.");

    a_mismatch_quiet: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (HOST_REQ.valid && !prog_mode && !sel_match)
        |=> HOST_RSP.valid && !HOST_RSP.claim && !HOST_RSP.reg_hit && !NIBBLE_BUS_EN)
        else $error("Mismatched cycle was answered or driven.");

    a_standby_entry: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (state_ff == FHP_IGNORE && frame_hi && !ARRAY_BUSY && !HOST_REQ.valid)
        |=> STANDBY && !NIBBLE_BUS_EN && state_ff == FHP_IDLE)
        else $error("Standby not entered after mismatch.");

    a_busy_low: assert property (@(posedge CLOCK) disable iff (!rst_n)
        $rose(ARRAY_BUSY) |=> READY_BUSY_OE && !STANDBY)
        else $error("Ready/busy not pulled low while busy.");

    a_busy_release: assert property (@(posedge CLOCK) disable iff (!rst_n)
        $fell(ARRAY_BUSY) |=> !READY_BUSY_OE)
        else $error("Ready/busy not released after operation.");

    a_resv_bits_zero: assert property (@(posedge CLOCK) disable iff (!rst_n)
        HOST_RSP.valid |-> HOST_RSP.rdata[7:5] == `FHP_REG_RESV)
        else $error("Reserved input register bits not zero.");

    a_reg_write_nohit: assert property (@(posedge CLOCK) disable iff (!rst_n)
        (HOST_REQ.valid && !prog_mode && HOST_REQ.write)
        |=> !HOST_RSP.reg_hit && HOST_RSP.rdata == 8'h00)
        else $error("Write to input register was treated as a read.");

    a_rsp_from_req: assert property (@(posedge CLOCK) disable iff (!rst_n)
        HOST_RSP.valid |-> $past(HOST_REQ.valid))
        else $error("Host answer given without a request.");

    a_nibble_claimed: assert property (@(posedge CLOCK) disable iff (!rst_n)
        state_ff != FHP_CLAIMED |-> !NIBBLE_BUS_EN)
        else $error("Nibble bus driven outside a claimed cycle.");

    a_claimed_awake: assert property (@(posedge CLOCK) disable iff (!rst_n)
        state_ff == FHP_CLAIMED |-> !STANDBY)
        else $error("Standby entered during a claimed cycle.");

    a_busy_awake: assert property (@(posedge CLOCK) disable iff (!rst_n)
        ARRAY_BUSY |=> !STANDBY)
        else $error("Standby entered while the array was busy.");

    a_host_addr_clear: assert property (@(posedge CLOCK) disable iff (!rst_n)
        !prog_mode |=> ARRAY_ADDR == `FHP_ADDR_RST)
        else $error("Array address moved in host mode.");

    a_host_port_quiet: assert property (@(posedge CLOCK) disable iff (!rst_n)
        !prog_mode |=> !ARRAY_WRITE && !PROG_DATA_OE)
        else $error("Programming port active in host mode.");

endmodule
`default_nettype wire

// *** testbench/fhp_array_model.sv ***
/*
 * Behavioural memory array on the far side of the programming port.
 * It stores the written bytes, reads back as erased where nothing was
 * written, and runs busy for a fixed time after each write.
 * Assumes the same clock and reset as the front end.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fhp_defs.svh"

module fhp_array_model (
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Array side of the front end.
    input  wire logic [`FHP_ARR_W-1:0]  addr,
    input  wire logic                   write,
    input  wire logic [`FHP_DATA_W-1:0] wdata,
    output logic [`FHP_DATA_W-1:0]      rdata,
    output logic                        busy
);
    logic [`FHP_DATA_W-1:0] mem [logic [`FHP_ARR_W-1:0]];
    logic [3:0]             busy_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Erased bytes read as all ones.
    always_comb begin
        rdata = mem.exists(addr) ? mem[addr] : 8'hFF;
    end

    ////////////////////////////////////////////////////////////////////////////
    // A write starts a self-timed operation of eight cycles.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt <= 4'h0;
        end else if (write === 1'b1) begin
            mem[addr] = wdata;
            busy_cnt <= 4'h8;
        end else if (busy_cnt != 4'h0) begin
            busy_cnt <= busy_cnt - 4'h1;
        end
    end

    assign busy = (busy_cnt != 4'h0);
endmodule
`default_nettype wire

// *** testbench/fhp_top_tb.sv ***
/*
 * Self-checking bench of the host port front end: register reads, device
 * select in both cycle kinds, standby and the programming port.
 * Assumes the array model stands on the array side.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fhp_defs.svh"

module fhp_top_tb;
    import fhp_pkg::*;

    logic                    clk;
    logic                    rst_b;
    logic [`FHP_GPI_W-1:0]   gpi;
    logic [`FHP_STRAP_W-1:0] strap;
    logic                    ic;
    logic                    frame_b;
    fhp_req_type             req;
    fhp_rsp_type             rsp;
    logic                    nib_en;
    logic                    standby;
    logic                    rc;
    logic [`FHP_ROW_W-1:0]   a;
    logic                    oe_b;
    logic                    we_b;
    logic                    prst_b;
    logic [`FHP_DATA_W-1:0]  din;
    logic [`FHP_DATA_W-1:0]  dout;
    logic                    doe;
    logic                    busy;
    logic [`FHP_DATA_W-1:0]  ardata;
    logic [`FHP_ARR_W-1:0]   aaddr;
    logic                    awr;
    logic [`FHP_DATA_W-1:0]  awdata;
    logic                    rb_o;
    logic                    rb_oe;
    int                      err_count;
    int                      n_tests;
    int                      wr_count;
    int                      cycles;

    fhp_top fhp_top_inst (
        .CLOCK(clk), .RST_B(rst_b), .GENERAL_INPUTS(gpi), .STRAP_SELECT(strap),
        .INTERFACE_SELECT_PIN(ic), .FRAME_STROBE_B(frame_b), .HOST_REQ(req),
        .HOST_RSP(rsp), .NIBBLE_BUS_EN(nib_en), .STANDBY(standby), .RC_STROBE(rc),
        .ROW_COL_ADDR(a), .READ_DRIVE_B(oe_b), .WRITE_STROBE_B(we_b),
        .PROG_RESET_B(prst_b), .PROG_DATA_I(din), .PROG_DATA_O(dout),
        .PROG_DATA_OE(doe), .ARRAY_BUSY(busy), .ARRAY_RDATA(ardata),
        .ARRAY_ADDR(aaddr), .ARRAY_WRITE(awr), .ARRAY_WDATA(awdata),
        .READY_BUSY_O(rb_o), .READY_BUSY_OE(rb_oe)
    );

    fhp_array_model fhp_array_model_inst (
        .clk(clk), .rst_n(rst_b), .addr(aaddr), .write(awr), .wdata(awdata),
        .rdata(ardata), .busy(busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (awr === 1'b1) wr_count <= wr_count + 1;
        if (cycles == 3000) begin
            err_count = err_count + 1;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (err_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic pw(input int n);
        repeat (n) @(negedge clk);
    endtask

    function automatic logic [31:0] lpc_addr(input logic [3:0] v);
        return (`FHP_REG_LPC_ADDR & ~`FHP_SEL_MASK) | {9'h0, v, 19'h0};
    endfunction

    // One decoded host cycle; the answer is looked at in its one cycle.
    task automatic host_cyc(input logic hub, input logic [3:0] sel, input logic [31:0] ad,
                            input logic wr, input logic ev, input logic ec, input logic eh);
        req = '{1'b1, hub, sel, ad, wr};
        @(negedge clk);
        req.valid = 1'b0;
        chk("rsp_valid", 32'(ev), 32'(rsp.valid));
        if (ev) begin
            chk("claim", 32'(ec), 32'(rsp.claim));
            chk("reg_hit", 32'(eh), 32'(rsp.reg_hit));
            chk("rdata", eh ? {27'h0, gpi} : 32'h0, 32'(rsp.rdata));
            chk("nibble_en", 32'(ec), 32'(nib_en));
        end
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0; n_tests = 0; wr_count = 0; cycles = 0;
        rst_b = 1'b0; gpi = 5'h00; strap = 4'h0; ic = 1'b0; frame_b = 1'b1;
        req = '0; rc = 1'b1; a = 11'h000; oe_b = 1'b1; we_b = 1'b1;
        prst_b = 1'b1; din = 8'h00;
        pw(4);
        rst_b = 1'b1;
        pw(5);
        chk("rsp_rst", 32'h0, 32'(rsp));
        chk("addr_rst", 32'h0, 32'(aaddr));
        chk("standby_idle", 32'h1, 32'(standby));
        frame_b = 1'b0;
        for (int s = 0; s < 16; s++) begin
            strap = 4'(s);
            gpi = 5'(s * 7 + 1);
            pw(3);
            host_cyc(1'b1, strap, `FHP_REG_HUB_ADDR, 1'b0, 1, 1, 1);
            host_cyc(1'b1, strap ^ 4'h1, `FHP_REG_HUB_ADDR, 1'b0, 1, 0, 0);
            host_cyc(1'b0, 4'h0, lpc_addr(~strap), 1'b0, 1, 1, 1);
            host_cyc(1'b0, 4'h0, lpc_addr(strap), 1'b0, 1, 0, 0);
        end
        host_cyc(1'b1, strap, `FHP_REG_HUB_ADDR, 1'b1, 1, 1, 0);
        chk("standby_busy", 32'h0, 32'(standby));
        frame_b = 1'b1;
        pw(5);
        chk("nibble_rel", 32'h0, 32'(nib_en));
        chk("standby", 32'h1, 32'(standby));
        host_cyc(1'b1, strap ^ 4'h1, `FHP_REG_HUB_ADDR, 1'b0, 1, 0, 0);
        chk("standby_ignore", 32'h1, 32'(standby));
        ic = 1'b1;
        pw(4);
        host_cyc(1'b1, strap, `FHP_REG_HUB_ADDR, 1'b0, 0, 0, 0);
        a = 11'h5A3;
        rc = 1'b0;
        pw(4);
        chk("row", 32'h5A3, 32'(aaddr[10:0]));
        a = 11'h0C6;
        rc = 1'b1;
        pw(4);
        chk("array_addr", 32'({8'hC6, 11'h5A3}), 32'(aaddr));
        din = 8'h3C;
        we_b = 1'b0;
        pw(4);
        we_b = 1'b1;
        pw(6);
        chk("write_count", 32'h1, 32'(wr_count));
        chk("write_data", 32'h3C, 32'(awdata));
        chk("busy_pull", 32'h1, 32'(rb_oe));
        chk("busy_level", 32'h0, 32'(rb_o));
        pw(12);
        chk("busy_release", 32'h0, 32'(rb_oe));
        oe_b = 1'b0;
        pw(4);
        chk("data_oe", 32'h1, 32'(doe));
        chk("data_out", 32'h3C, 32'(dout));
        we_b = 1'b0;
        pw(4);
        we_b = 1'b1;
        pw(6);
        chk("write_refused", 32'h1, 32'(wr_count));
        oe_b = 1'b1;
        pw(4);
        chk("data_float", 32'h0, 32'(doe));
        prst_b = 1'b0;
        pw(4);
        chk("addr_prog_rst", 32'h0, 32'(aaddr));
        give_verdict();
    end
endmodule
`default_nettype wire
